// ===== hw/gpr_pkg.sv
`default_nettype none
package gpr_pkg;
  // Field widths of the 16-bit gray scale packet
  localparam int CMD_W    = 6;
  localparam int ADDR_W   = 10;
  localparam int LEN_W    = 10;
  localparam int PAR_W    = 4;
  localparam int SPARE_W  = 2;
  localparam int HDR_W    = 48;
  localparam int WORD_W   = 16;
  localparam int CHAN_N   = 12;
  localparam int IDX_W    = 4;
  // Command code of a 16-bit gray scale packet
  localparam logic [CMD_W-1:0] CMD_GRAY16 = 6'h3f;
  // Parity bit positions
  localparam int PAR_LEN  = 0;
  localparam int PAR_ADDR = 1;
  localparam int PAR_CMD  = 2;
  localparam int PAR_ALL  = 3;
  // Idle prefix length in link clock periods, system clock period
  localparam int PREFIX_CKI    = 172;
  localparam int SYS_PERIOD_NS = 8;
  // PWM counter layout: 64 segments of 1024 counts
  localparam int PWM_W    = 16;
  localparam int SEG_W    = 6;
  localparam int POS_W    = 10;
  localparam logic [WORD_W-1:0] DUTY_RST = 16'h0000;
  localparam logic [IDX_W-1:0]  TOP_CHAN = 4'hb;
  // Received header fields, first bit sent is the MSB
  typedef struct packed {
    logic [CMD_W-1:0]   cmd;
    logic [ADDR_W-1:0]  addr;
    logic [CMD_W-1:0]   cmd_copy;
    logic [LEN_W-1:0]   chain_len;
    logic [PAR_W-1:0]   par;
    logic [SPARE_W-1:0] spare_header_bits;
    logic [LEN_W-1:0]   chain_len_copy;
  } gpr_header_s;
  // One channel word on its way to the shadow store
  typedef struct packed {
    logic [IDX_W-1:0]  idx;
    logic [WORD_W-1:0] value;
  } gpr_word_s;
  // Receiver framing states
  typedef enum logic [1:0] {
    ST_WAIT  = 2'b00,
    ST_ARMED = 2'b01,
    ST_HEAD  = 2'b10,
    ST_DATA  = 2'b11
  } gpr_state_e;
endpackage
`default_nettype wire

// ===== hw/gpr_receiver.sv
`default_nettype none
// Word FIFO with honest full and empty flags
module gpr_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_sys_in,
  input  wire logic         nrst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];        // Storage array
  logic [AW:0]  wr_reg, wr_next;    // Write pointer with wrap bit
  logic [AW:0]  rd_reg, rd_next;    // Read pointer with wrap bit
  logic         full, empty;
  // Full when pointers differ only in wrap bit
  always_comb begin
    empty   = (wr_reg == rd_reg);
    full    = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
    wr_next = (in_valid_in && !full) ? wr_reg + 1'b1 : wr_reg;
    rd_next = (out_ready_in && !empty) ? rd_reg + 1'b1 : rd_reg;
  end
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[rd_reg[AW-1:0]];
  // Pointer registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end
  // Storage write, no reset needed
  always_ff @(posedge clk_sys_in) begin
    if (in_valid_in && !full) begin
      mem[wr_reg[AW-1:0]] <= in_data_in;
    end
  end
endmodule

// Functional notes
// - 10-bit mode: on time is value over 1024
// - Sixteen-bit words, twelve per device
// - 48-bit header precedes all channel data
// - Command field must be all ones
// - Mismatched command copy discards packet
// - Chain length equals devices minus one
// - Any parity mismatch discards packet
// - Parity zero covers chain length field
// - Parity one covers address field
// - Parity two covers command field
// - Parity three covers parity bits two..zero
// - Spare header bits are ignored
// - Chain length repeated at header end
// - Highest third-group channel word comes first
// - Farthest device block first, nearest last
// - 16-bit on time split over 64 segments
module gpr_receiver
  import gpr_pkg::*;
#(
  parameter int CKI_PERIOD_NS = 80,
  parameter int FIFO_DEPTH    = 8
) (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              nrst_in,
  // Serial link pins
  input  wire logic              serial_clock_in,
  input  wire logic              serial_data_in,
  // Configuration
  input  wire logic              gray10_mode_in,
  // Channel outputs, index 11 is third_group_top_output
  output logic [CHAN_N-1:0]      led_on_out,
  // Status
  output logic                   packet_ok_out,
  output logic                   header_err_out,
  output logic                   overflow_out,
  output logic [LEN_W-1:0]       chain_len_out
);
  // Least idle time rounds up to whole system cycles
  localparam int PREFIX_CYC =
    (PREFIX_CKI * CKI_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int IC_W = $clog2(PREFIX_CYC + 1) + 1;
  localparam logic [IC_W-1:0] PREFIX_LIM = IC_W'(PREFIX_CYC);

  logic [2:0] ck_s;                 // Link clock synchroniser and history
  logic [1:0] dt_s;                 // Link data synchroniser
  logic [1:0] md_s;                 // Mode pin synchroniser
  logic       rise, fall;           // Link clock edges
  // Two flops before any logic, third flop for edge finding
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ck_s <= '0;
      dt_s <= '0;
      md_s <= '0;
    end else begin
      ck_s <= {ck_s[1:0], serial_clock_in};
      dt_s <= {dt_s[0], serial_data_in};
      md_s <= {md_s[0], gray10_mode_in};
    end
  end
  assign rise = ck_s[1] & ~ck_s[2];
  assign fall = ~ck_s[1] & ck_s[2];

  gpr_state_e           state_reg, state_next;   // Framing state
  logic [IC_W-1:0]      idle_reg, idle_next;     // Idle cycle count
  logic [HDR_W-1:0]     shift_reg, shift_next;   // Incoming bits
  logic [5:0]           bit_reg, bit_next;       // Bit within header/word
  logic [IDX_W-1:0]     word_reg, word_next;     // Word within block
  logic [LEN_W-1:0]     blk_reg, blk_next;       // Block within packet
  logic [LEN_W-1:0]     len_reg, len_next;       // Accepted chain length
  logic                 ok_reg, ok_next;
  logic                 herr_reg, herr_next;
  logic                 ovf_reg, ovf_next;
  logic [HDR_W-1:0]     shifted;
  gpr_header_s          hdr;
  logic                 cmd_ok, copy_ok, len_ok, par_ok, hdr_last;
  logic [PAR_W-1:0]     par_exp;
  gpr_word_s            push_word;
  logic                 push, push_ready;

  // Header checks on the value including the bit now arriving
  always_comb begin
    shifted = {shift_reg[HDR_W-2:0], dt_s[1]};
    hdr     = gpr_header_s'(shifted);
    par_exp[PAR_LEN]  = ^hdr.chain_len;
    par_exp[PAR_ADDR] = ^hdr.addr;
    par_exp[PAR_CMD]  = ^hdr.cmd;
    par_exp[PAR_ALL]  = ^par_exp[PAR_CMD:PAR_LEN];
    cmd_ok  = (hdr.cmd == CMD_GRAY16);
    copy_ok = (hdr.cmd_copy == hdr.cmd);
    len_ok  = (hdr.chain_len_copy == hdr.chain_len);
    par_ok  = (hdr.par == par_exp);
    // Spare header bits take no part in any check
    hdr_last = (bit_reg == 6'(HDR_W - 1));
  end

  // Framing next-state logic
  always_comb begin
    state_next = state_reg;
    idle_next  = idle_reg;
    shift_next = shift_reg;
    bit_next   = bit_reg;
    word_next  = word_reg;
    blk_next   = blk_reg;
    len_next   = len_reg;
    ok_next    = 1'b0;
    herr_next  = 1'b0;
    ovf_next   = 1'b0;
    push       = 1'b0;
    push_word  = '{idx: TOP_CHAN - word_reg, value: shifted[WORD_W-1:0]};
    // Idle prefix: both lines low and no clock edge
    if (ck_s[1] || dt_s[1] || rise || fall) begin
      idle_next = '0;
    end else if (idle_reg != PREFIX_LIM) begin
      idle_next = idle_reg + 1'b1;
    end
    if (idle_next == PREFIX_LIM) begin
      // Prefix long enough: resync, abandon any packet
      state_next = ST_ARMED;
      bit_next   = '0;
    end else if (rise) begin
      case (state_reg)
        ST_ARMED: begin
          shift_next = shifted;
          bit_next   = 6'd1;
          state_next = ST_HEAD;
        end
        ST_HEAD: begin
          shift_next = shifted;
          bit_next   = bit_reg + 1'b1;
          if (hdr_last) begin
            bit_next = '0;
            if (cmd_ok && copy_ok && len_ok && par_ok) begin
              state_next = ST_DATA;
              len_next   = hdr.chain_len;
              word_next  = '0;
              blk_next   = '0;
            end else begin
              state_next = ST_WAIT;
              herr_next  = 1'b1;
            end
          end
        end
        ST_DATA: begin
          shift_next = shifted;
          bit_next   = bit_reg + 1'b1;
          if (bit_reg == 6'(WORD_W - 1)) begin
            bit_next  = '0;
            word_next = word_reg + 1'b1;
            // Only the last block belongs to this device
            if (blk_reg == len_reg) begin
              push     = 1'b1;
              ovf_next = !push_ready;
            end
            if (word_reg == IDX_W'(CHAN_N - 1)) begin
              word_next = '0;
              blk_next  = blk_reg + 1'b1;
              if (blk_reg == len_reg) begin
                state_next = ST_WAIT;
                ok_next    = 1'b1;
              end
            end
          end
        end
        default: begin
          state_next = ST_WAIT;
        end
      endcase
    end
  end

  // Framing registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_WAIT;
      idle_reg  <= '0;
      shift_reg <= '0;
      bit_reg   <= '0;
      word_reg  <= '0;
      blk_reg   <= '0;
      len_reg   <= '0;
      ok_reg    <= 1'b0;
      herr_reg  <= 1'b0;
      ovf_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      idle_reg  <= idle_next;
      shift_reg <= shift_next;
      bit_reg   <= bit_next;
      word_reg  <= word_next;
      blk_reg   <= blk_next;
      len_reg   <= len_next;
      ok_reg    <= ok_next;
      herr_reg  <= herr_next;
      ovf_reg   <= ovf_next;
    end
  end

  gpr_word_s pop_word;
  logic      pop_valid, pop_ready;
  // Word buffer between link and shadow store
  gpr_fifo #(
    .W     ($bits(gpr_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (push),
    .in_ready_out  (push_ready),
    .in_data_in    (push_word),
    .out_valid_out (pop_valid),
    .out_ready_in  (pop_ready),
    .out_data_out  (pop_word)
  );

  logic [WORD_W-1:0] shadow_reg [CHAN_N];  // Collected channel values
  logic [WORD_W-1:0] shadow_next [CHAN_N];
  logic [WORD_W-1:0] duty_reg [CHAN_N];    // Active duty values
  logic [WORD_W-1:0] duty_next [CHAN_N];
  logic [IDX_W-1:0]  scnt_reg, scnt_next;  // Words collected
  logic              pend_reg, pend_next;  // Full set awaiting commit
  logic [PWM_W-1:0]  pwm_reg, pwm_next;    // PWM count, one per cycle
  logic [CHAN_N-1:0] on_next;
  logic              wrap;
  // Drain stalls while a full set waits for the PWM boundary
  assign pop_ready = !pend_reg;
  always_comb begin
    shadow_next = shadow_reg;
    duty_next   = duty_reg;
    scnt_next   = scnt_reg;
    pend_next   = pend_reg;
    pwm_next    = pwm_reg + 1'b1;
    wrap = md_s[1] ? (&pwm_reg[POS_W-1:0]) : (&pwm_reg);
    if (pend_reg && wrap) begin
      duty_next = shadow_reg;
      pend_next = 1'b0;
    end else if (pop_valid && pop_ready) begin
      // Take a word only when the FIFO really lets it go
      shadow_next[pop_word.idx] = pop_word.value;
      scnt_next = (pop_word.idx == TOP_CHAN) ? IDX_W'(1) : scnt_reg + 1'b1;
      if (pop_word.idx == '0 && scnt_reg == IDX_W'(CHAN_N - 1)) begin
        pend_next = 1'b1;
      end
    end
    for (int c = 0; c < CHAN_N; c++) begin
      if (md_s[1]) begin
        // Conventional PWM on the low ten bits
        on_next[c] = pwm_reg[POS_W-1:0] < duty_reg[c][POS_W-1:0];
      end else begin
        // Coarse part each segment, one extra count in early segments
        on_next[c] = {1'b0, pwm_reg[POS_W-1:0]} <
                     ({1'b0, duty_reg[c][WORD_W-1:SEG_W]} +
                      (POS_W+1)'(pwm_reg[PWM_W-1:POS_W] <
                                 duty_reg[c][SEG_W-1:0]));
      end
    end
  end

  // Drain, duty and PWM registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int c = 0; c < CHAN_N; c++) begin
        shadow_reg[c] <= DUTY_RST;
        duty_reg[c]   <= DUTY_RST;
      end
      scnt_reg   <= '0;
      pend_reg   <= 1'b0;
      pwm_reg    <= '0;
      led_on_out <= '0;
    end else begin
      shadow_reg <= shadow_next;
      duty_reg   <= duty_next;
      scnt_reg   <= scnt_next;
      pend_reg   <= pend_next;
      pwm_reg    <= pwm_next;
      led_on_out <= on_next;
    end
  end
  assign packet_ok_out  = ok_reg;
  assign header_err_out = herr_reg;
  assign overflow_out   = ovf_reg;
  assign chain_len_out  = len_reg;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  sequence hdr_end_s;
    state_reg == ST_HEAD && rise && hdr_last && idle_next != PREFIX_LIM;
  endsequence
  hdr_length_a: assert property (
    $rose(state_reg == ST_DATA) |-> $past(bit_reg) == 6'd47)
    else $error("data entered before 48 header bits");
  cmd_reject_a: assert property (
    hdr_end_s ##0 !copy_ok |=> state_reg == ST_WAIT && header_err_out)
    else $error("command copy mismatch accepted");
  parity_reject_a: assert property (
    hdr_end_s ##0 (hdr.par[PAR_ALL] != ^hdr.par[PAR_CMD:PAR_LEN]) |=>
    state_reg != ST_DATA)
    else $error("bad parity accepted");
  len_reject_a: assert property (
    hdr_end_s ##0 !len_ok |=> state_reg == ST_WAIT)
    else $error("chain length copy mismatch accepted");
  cmd_accept_a: assert property (
    hdr_end_s ##0 (cmd_ok && copy_ok && len_ok && par_ok) |=>
    state_reg == ST_DATA && chain_len_out == $past(hdr.chain_len))
    else $error("good header not accepted");
  word_order_a: assert property (
    push && word_reg == '0 |-> push_word.idx == TOP_CHAN)
    else $error("first word not top channel");
  last_block_a: assert property (
    push |-> blk_reg == chain_len_out && state_reg == ST_DATA)
    else $error("word taken from wrong block");
  commit_a: assert property (
    pend_reg && wrap |=> !pend_reg && duty_reg[0] == $past(shadow_reg[0]))
    else $error("duty not committed at boundary");
  gray10_off_a: assert property (
    md_s[1] && duty_reg[0][POS_W-1:0] == '0 |=> !led_on_out[0])
    else $error("zero duty output turned on");
  segment_on_a: assert property (
    !md_s[1] && pwm_reg[POS_W-1:0] == '0 &&
    duty_reg[0][WORD_W-1:SEG_W] != '0 |=> led_on_out[0])
    else $error("segment start not on");
endmodule
`default_nettype wire

// ===== tb/gpr_link_model.sv
`default_nettype none
// Upstream sender: drives the two-wire link in step with the system clock
module gpr_link_model (
  // Clock
  input  wire logic clk_sys_in,
  // Link pins towards the receiver
  output var logic  serial_clock_out,
  output var logic  serial_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF_CYC = 5;  // 40 ns half of the 80 ns link period

  // Lines start low, as in a prefix
  initial begin
    serial_clock_out = 1'b0;
    serial_data_out  = 1'b0;
  end

  // Prefix: both lines low and still for n system cycles
  task automatic idle(input int n);
    @(posedge clk_sys_in);
    serial_clock_out <= 1'b0;
    serial_data_out  <= 1'b0;
    repeat (n - 1) @(posedge clk_sys_in);
  endtask

  // One bit: data changes while clock is low, then a rising edge
  task automatic put_bit(input logic b);
    @(posedge clk_sys_in);
    serial_clock_out <= 1'b0;
    serial_data_out  <= b;
    repeat (HALF_CYC) @(posedge clk_sys_in);
    serial_clock_out <= 1'b1;
    repeat (HALF_CYC - 1) @(posedge clk_sys_in);
  endtask

  // Header, first bit sent is bit 47
  task automatic send_hdr(input logic [47:0] h);
    for (int i = 47; i >= 0; i--) put_bit(h[i]);
  endtask

  // Channel word, MSB first
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) put_bit(w[i]);
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_grayscale_packet_receiver.sv
`default_nettype none
module tb_grayscale_packet_receiver;
  import gpr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end

  logic              clk_sys_in;      // System clock
  logic              nrst_in;         // Reset, active low
  logic              gray10_mode_in;  // PWM mode select
  logic              sclk;            // Link clock from the model
  logic              sdat;            // Link data from the model
  logic [CHAN_N-1:0] led_on_out;      // Channel outputs
  logic              packet_ok_out;   // Packet accepted pulse
  logic              header_err_out;  // Header rejected pulse
  logic              overflow_out;    // Word lost pulse
  logic [LEN_W-1:0]  chain_len_out;   // Last accepted chain length
  int                err_count = 0;   // Mismatches
  int                checks = 0;      // Comparisons
  int                ok_n;            // Accept pulses seen
  int                err_n;           // Reject pulses seen
  int                ov_n;            // Overflow pulses seen
  int                cyc = 0;         // Cycles run

  gpr_receiver gpr_receiver_i (
    .clk_sys_in     (clk_sys_in),
    .nrst_in        (nrst_in),
    .serial_clock_in(sclk),
    .serial_data_in (sdat),
    .gray10_mode_in (gray10_mode_in),
    .led_on_out     (led_on_out),
    .packet_ok_out  (packet_ok_out),
    .header_err_out (header_err_out),
    .overflow_out   (overflow_out),
    .chain_len_out  (chain_len_out)
  );

  gpr_link_model gpr_link_model_i (
    .clk_sys_in      (clk_sys_in),
    .serial_clock_out(sclk),
    .serial_data_out (sdat)
  );

  // Clock, 8 ns period
  initial clk_sys_in = 1'b0;
  always #4 clk_sys_in = ~clk_sys_in;

  // Pulse counters and hang guard
  always @(posedge clk_sys_in) begin
    cyc++;
    if (packet_ok_out === 1'b1) ok_n++;
    if (header_err_out === 1'b1) err_n++;
    if (overflow_out === 1'b1) ov_n++;
    // Scenarios need about 34000 cycles; stays below the first 16-bit wrap
    if (cyc == 45000) begin
      err_count++;
      summarize();
    end
  end

  // Header with chosen copies, spare bits and parity bits to flip
  function automatic logic [HDR_W-1:0] mk_hdr(input logic [CMD_W-1:0] c2,
      input logic [LEN_W-1:0] l, input logic [LEN_W-1:0] l2,
      input logic [SPARE_W-1:0] sp, input logic [PAR_W-1:0] flip);
    gpr_header_s h;
    h.cmd               = CMD_GRAY16;
    h.addr              = '0;
    h.cmd_copy          = c2;
    h.chain_len         = l;
    h.par[PAR_LEN]      = ^l;
    h.par[PAR_ADDR]     = 1'b0;
    h.par[PAR_CMD]      = ^CMD_GRAY16;
    h.par[PAR_ALL]      = ^h.par[2:0];
    h.par               = h.par ^ flip;
    h.spare_header_bits = sp;
    h.chain_len_copy    = l2;
    return h;
  endfunction

  // Word k of the kept block
  function automatic logic [WORD_W-1:0] wd(input int k);
    return {6'h2a, 10'(k * 70 + 5)};
  endfunction

  // Prefix, clear counters, header
  task automatic frame(input logic [HDR_W-1:0] h);
    gpr_link_model_i.idle(1730);
    ok_n  = 0;
    err_n = 0;
    gpr_link_model_i.send_hdr(h);
  endtask

  // Two devices; only the nearest (last) block is kept
  task automatic t_good();
    int cnt [CHAN_N];
    @(posedge clk_sys_in);
    gray10_mode_in <= 1'b1;
    frame(mk_hdr(CMD_GRAY16, 10'h001, 10'h001, 2'b11, 4'h0));
    for (int k = 0; k < 12; k++) gpr_link_model_i.send_word(16'hffff);
    for (int k = 0; k < 12; k++) gpr_link_model_i.send_word(wd(k));
    repeat (12) @(posedge clk_sys_in);
    `CHK("ok", 1, ok_n)
    `CHK("err", 0, err_n)
    `CHK("len", 10'h001, chain_len_out)
    repeat (2100) @(posedge clk_sys_in);
    for (int i = 0; i < CHAN_N; i++) cnt[i] = 0;
    repeat (1024) begin
      @(posedge clk_sys_in);
      #1;
      for (int i = 0; i < CHAN_N; i++) if (led_on_out[i] === 1'b1) cnt[i]++;
    end
    for (int k = 0; k < 12; k++) `CHK("duty", k * 70 + 5, cnt[11 - k])
    `CHK("duty_top", 5, cnt[TOP_CHAN])
  endtask

  // A packet without a prefix is ignored
  task automatic t_no_prefix();
    ok_n  = 0;
    err_n = 0;
    gpr_link_model_i.send_hdr(mk_hdr(CMD_GRAY16, 10'h000, 10'h000, 2'b00,
                                     4'h0));
    for (int k = 0; k < 12; k++) gpr_link_model_i.send_word(wd(k));
    repeat (12) @(posedge clk_sys_in);
    `CHK("np_ok", 0, ok_n + err_n)
    `CHK("np_len", 10'h001, chain_len_out)
  endtask

  // Header rejection: pulse once, keep old chain length
  task automatic reject(input logic [HDR_W-1:0] h, output int e);
    frame(h);
    gpr_link_model_i.send_word(wd(0));
    repeat (8) @(posedge clk_sys_in);
    e = (err_n == 1 && ok_n == 0 && chain_len_out === 10'h001) ? 1 : 0;
  endtask

  // Differing command copy
  task automatic t_cmd_copy();
    int e;
    @(posedge clk_sys_in);
    gray10_mode_in <= 1'b0;
    reject(mk_hdr(6'h3e, 10'h002, 10'h002, 2'b00, 4'h0), e);
    `CHK("cmd_copy", 1, e)
  endtask

  // Each parity bit wrong in turn
  task automatic t_parity();
    int e;
    for (int i = 0; i < PAR_W; i++) begin
      reject(mk_hdr(CMD_GRAY16, 10'h002, 10'h002, 2'b00, 4'(1 << i)), e);
      `CHK("parity", 1, e)
    end
  endtask

  // Differing chain length copy
  task automatic t_len_copy();
    int e;
    reject(mk_hdr(CMD_GRAY16, 10'h002, 10'h003, 2'b00, 4'h0), e);
    `CHK("len_copy", 1, e)
  endtask

  // 16-bit mode: first set waits for the full 65536-count wrap, so the
  // second packet's words fill the 8-word FIFO and the last 4 are lost
  task automatic t_overflow();
    ov_n = 0;
    frame(mk_hdr(CMD_GRAY16, 10'h000, 10'h000, 2'b00, 4'h0));
    for (int k = 0; k < 12; k++) gpr_link_model_i.send_word(wd(k));
    frame(mk_hdr(CMD_GRAY16, 10'h000, 10'h000, 2'b00, 4'h0));
    for (int k = 0; k < 12; k++) gpr_link_model_i.send_word(wd(k));
    repeat (12) @(posedge clk_sys_in);
    `CHK("ovf", 4, ov_n)
    `CHK("ovf_ok", 1, ok_n)
    `CHK("ovf_len", 10'h000, chain_len_out)
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    nrst_in        = 1'b0;
    gray10_mode_in = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    t_good();
    t_no_prefix();
    t_cmd_copy();
    t_parity();
    t_len_copy();
    t_overflow();
    summarize();
  end
endmodule
`default_nettype wire
